// *** rtl/clc_master.sv ***
// Cache-line transaction issuer on the coherent address and write channels
`timescale 1ns/100ps
`include "clc_regs.svh"
module clc_master #(
    parameter int DATA_W = 64,
    parameter int ADDR_W = 32,
    parameter int LINE_BYTES = 64
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire clc_pkg::clc_op_e req_op,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [1:0] req_domain,
    input wire logic req_excl,
    input wire logic req_wrap,
    input wire logic [2:0] req_prot,
    input wire logic [3:0] req_qos,
    // Write data in
    input wire logic wd_valid,
    output logic wd_ready,
    input wire logic [DATA_W-1:0] wd_data,
    // Read address channel
    output logic arvalid,
    input wire logic arready,
    output logic [ADDR_W-1:0] araddr,
    output clc_pkg::clc_chan_s ar_chan,
    // Write address channel
    output logic awvalid,
    input wire logic awready,
    output logic [ADDR_W-1:0] awaddr,
    output clc_pkg::clc_chan_s aw_chan,
    // Write data channel
    output logic wvalid,
    input wire logic wready,
    output logic [DATA_W-1:0] wdata,
    output logic [DATA_W/8-1:0] wstrb,
    output logic wlast
);

    localparam int BUS_BYTES = DATA_W / 8;
    localparam int BEATS = LINE_BYTES / BUS_BYTES;
    localparam int LINE_OFF = $clog2(LINE_BYTES);
    localparam int BEAT_OFF = $clog2(BUS_BYTES);
    localparam logic [7:0] LEN = 8'(BEATS - 1);
    localparam logic [2:0] SIZE = 3'(BEAT_OFF);
    localparam logic [ADDR_W-1:0] LINE_MASK = ADDR_W'(LINE_BYTES - 1);
    localparam logic [ADDR_W-1:0] BEAT_MASK = ADDR_W'(BUS_BYTES - 1);

    typedef struct packed {
        clc_pkg::clc_st_e st;
        clc_pkg::clc_op_e op;
        logic [ADDR_W-1:0] addr;
        clc_pkg::clc_chan_s chan;
        logic is_write;
        logic has_data;
        logic arvalid;
        logic awvalid;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [BUS_BYTES-1:0] wstrb;
        logic wlast;
        logic [7:0] ld_cnt;
        logic req_ready;
        logic wd_ready;
    } clc_state_s;

    clc_state_s s_r;
    clc_state_s s_nxt;
    clc_pkg::clc_attr_s attr;

    clc_attr u_attr (
        .op(req_op),
        .domain_in(req_domain),
        .excl_in(req_excl),
        .attr(attr)
    );

    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            clc_pkg::CLC_ST_IDLE: begin
                s_nxt.req_ready = 1'b1;
                if (req_valid && s_r.req_ready) begin
                    s_nxt.req_ready = 1'b0;
                    s_nxt.st = clc_pkg::CLC_ST_ADDR;
                    s_nxt.op = req_op;
                    s_nxt.is_write = attr.is_write;
                    s_nxt.has_data = attr.has_data;
                    // Single-beat lines cannot wrap
                    if (req_wrap && BEATS > 1) begin
                        s_nxt.chan.burst = `CLC_BURST_WRAP;
                        s_nxt.addr = req_addr & ~BEAT_MASK;
                    end else begin
                        s_nxt.chan.burst = `CLC_BURST_INCR;
                        s_nxt.addr = req_addr & ~LINE_MASK;
                    end
                    s_nxt.chan.len = LEN;
                    s_nxt.chan.size = SIZE;
                    s_nxt.chan.lock = attr.lock;
                    s_nxt.chan.cache = `CLC_CACHE_VAL;
                    s_nxt.chan.prot = req_prot;
                    s_nxt.chan.qos = req_qos;
                    s_nxt.chan.domain = attr.domain;
                    s_nxt.chan.bar = `CLC_BAR_NORMAL;
                    s_nxt.chan.snoop = attr.snoop;
                    s_nxt.arvalid = !attr.is_write;
                    s_nxt.awvalid = attr.is_write;
                    s_nxt.ld_cnt = 8'h00;
                end
            end
            clc_pkg::CLC_ST_ADDR: begin
                if ((s_r.arvalid && arready) || (s_r.awvalid && awready)) begin
                    s_nxt.arvalid = 1'b0;
                    s_nxt.awvalid = 1'b0;
                    if (s_r.has_data) begin
                        s_nxt.st = clc_pkg::CLC_ST_DATA;
                        s_nxt.wd_ready = 1'b1;
                    end else begin
                        s_nxt.st = clc_pkg::CLC_ST_IDLE;
                        s_nxt.req_ready = 1'b1;
                    end
                end
            end
            clc_pkg::CLC_ST_DATA: begin
                if (s_r.wvalid && wready) begin
                    s_nxt.wvalid = 1'b0;
                    if (s_r.wlast) begin
                        s_nxt.st = clc_pkg::CLC_ST_IDLE;
                        s_nxt.req_ready = 1'b1;
                        s_nxt.wlast = 1'b0;
                    end else begin
                        s_nxt.wd_ready = 1'b1;
                    end
                end
                if (wd_valid && s_r.wd_ready) begin
                    s_nxt.wd_ready = 1'b0;
                    s_nxt.wvalid = 1'b1;
                    s_nxt.wdata = wd_data;
                    s_nxt.wstrb = '1;
                    s_nxt.wlast = (s_r.ld_cnt == LEN);
                    s_nxt.ld_cnt = s_r.ld_cnt + 8'h01;
                end
            end
            default: begin
                s_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state
    assign req_ready = s_r.req_ready;
    assign wd_ready = s_r.wd_ready;
    assign arvalid = s_r.arvalid;
    assign araddr = s_r.addr;
    assign ar_chan = s_r.chan;
    assign awvalid = s_r.awvalid;
    assign awaddr = s_r.addr;
    assign aw_chan = s_r.chan;
    assign wvalid = s_r.wvalid;
    assign wdata = s_r.wdata;
    assign wstrb = s_r.wstrb;
    assign wlast = s_r.wlast;

    // Checks
    wire logic av = arvalid || awvalid;
    wire clc_pkg::clc_chan_s ch = arvalid ? ar_chan : aw_chan;
    wire logic [ADDR_W-1:0] ad = arvalid ? araddr : awaddr;
    wire logic relaxed = (s_r.op == clc_pkg::CLC_OP_CSHARED) ||
                         (s_r.op == clc_pkg::CLC_OP_CINVAL) ||
                         (s_r.op == clc_pkg::CLC_OP_MINVAL) ||
                         (s_r.op == clc_pkg::CLC_OP_WEVICT);
    wire logic excl_ok = (s_r.op == clc_pkg::CLC_OP_RCLEAN) ||
                         (s_r.op == clc_pkg::CLC_OP_RSHARED) ||
                         (s_r.op == clc_pkg::CLC_OP_CUNIQUE);

    // Burst length and size
    a_len_line: assert property (@(posedge core_clk) disable iff (!nrst)
        av |-> (ch.len == LEN) && (BEATS == 1 || BEATS == 2 || BEATS == 4 ||
                                   BEATS == 8 || BEATS == 16))
        else $error("burst length is not one whole line");

    a_len_pow2: assert property (@(posedge core_clk) disable iff (!nrst)
        av |-> ((ch.len + 8'h01) & ch.len) == 8'h00 && ch.len <= 8'h0F)
        else $error("burst length not 1, 2, 4, 8 or 16 beats");

    a_size_full: assert property (@(posedge core_clk) disable iff (!nrst)
        av |-> (8'd1 << ch.size) == 8'(BUS_BYTES))
        else $error("beat size narrower than bus");

    a_line_total: assert property (@(posedge core_clk) disable iff (!nrst)
        av |-> (int'(ch.len) + 1) * (1 << ch.size) == LINE_BYTES)
        else $error("transaction not one line in size");

    a_dataless_len: assert property (@(posedge core_clk) disable iff (!nrst)
        av && !s_r.has_data |-> (int'(ch.len) + 1) * (1 << ch.size) == LINE_BYTES)
        else $error("dataless kind does not encode a full line");

    // Address alignment and burst type
    a_incr_align: assert property (@(posedge core_clk) disable iff (!nrst)
        av && ch.burst == `CLC_BURST_INCR |-> (ad & LINE_MASK) == '0)
        else $error("incrementing burst not line aligned");

    a_wrap_align: assert property (@(posedge core_clk) disable iff (!nrst)
        av && ch.burst == `CLC_BURST_WRAP |-> (ad & BEAT_MASK) == '0 && BEATS > 1)
        else $error("wrapping burst not beat aligned");

    a_no_fixed: assert property (@(posedge core_clk) disable iff (!nrst)
        av |-> ch.burst != `CLC_BURST_FIXED)
        else $error("fixed burst issued");

    // Attributes
    a_dom_share: assert property (@(posedge core_clk) disable iff (!nrst)
        av && !relaxed |-> ch.domain == `CLC_DOM_INNER || ch.domain == `CLC_DOM_OUTER)
        else $error("domain not shareable");

    a_dom_nosys: assert property (@(posedge core_clk) disable iff (!nrst)
        av |-> ch.domain != `CLC_DOM_SYSTEM)
        else $error("system domain issued");

    a_dom_keep: assert property (@(posedge core_clk) disable iff (!nrst)
        ce && req_valid && req_ready &&
        (req_domain == `CLC_DOM_INNER || req_domain == `CLC_DOM_OUTER) |=>
        ch.domain == $past(req_domain))
        else $error("legal shareable domain altered");

    a_bar_cache: assert property (@(posedge core_clk) disable iff (!nrst)
        av |-> ch.bar == `CLC_BAR_NORMAL)
        else $error("barrier attribute set");

    a_cache_mod: assert property (@(posedge core_clk) disable iff (!nrst)
        av |-> ch.cache[`CLC_CACHE_MOD_BIT])
        else $error("access not modifiable");

    a_lock_normal: assert property (@(posedge core_clk) disable iff (!nrst)
        av && !excl_ok |-> ch.lock == `CLC_LOCK_NORMAL)
        else $error("exclusive on forbidden kind");

    a_excl_kept: assert property (@(posedge core_clk) disable iff (!nrst)
        ce && req_valid && req_ready && (req_op == clc_pkg::CLC_OP_RCLEAN) |=>
        arvalid && ar_chan.lock == $past(req_excl))
        else $error("exclusive request lost");

    a_excl_shared: assert property (@(posedge core_clk) disable iff (!nrst)
        ce && req_valid && req_ready &&
        (req_op == clc_pkg::CLC_OP_RSHARED || req_op == clc_pkg::CLC_OP_CUNIQUE) |=>
        ch.lock == $past(req_excl))
        else $error("exclusive wish lost");

    a_prot_pass: assert property (@(posedge core_clk) disable iff (!nrst)
        ce && req_valid && req_ready |=> ch.prot == $past(req_prot) && ch.qos == $past(req_qos))
        else $error("prot or qos altered");

    // Write data
    a_strb_full: assert property (@(posedge core_clk) disable iff (!nrst)
        wvalid |-> &wstrb)
        else $error("partial write strobe");

    a_w_kind: assert property (@(posedge core_clk) disable iff (!nrst)
        wvalid |-> s_r.op == clc_pkg::CLC_OP_WLU || s_r.op == clc_pkg::CLC_OP_WEVICT)
        else $error("write beat for a kind without data");

    a_w_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        wvalid && !wready |=> wvalid && $stable(wdata) && $stable(wlast))
        else $error("write beat changed before taken");

    a_wlast_end: assert property (@(posedge core_clk) disable iff (!nrst)
        wvalid && wlast |-> s_r.ld_cnt == 8'(BEATS))
        else $error("last beat not at end of line");

    a_wlast_early: assert property (@(posedge core_clk) disable iff (!nrst)
        wvalid && !wlast |-> s_r.ld_cnt < 8'(BEATS))
        else $error("line runs past its last beat");

    // Handshakes and sizing
    a_addr_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        av && !(arvalid ? arready : awready) |=> av && $stable(ad) && $stable(ch.len))
        else $error("address request dropped before taken");

    a_one_chan: assert property (@(posedge core_clk) disable iff (!nrst)
        !(arvalid && awvalid))
        else $error("both address channels valid");

    a_rd_chan: assert property (@(posedge core_clk) disable iff (!nrst)
        arvalid |-> s_r.op <= clc_pkg::CLC_OP_MINVAL)
        else $error("write kind on read address channel");

    a_wr_chan: assert property (@(posedge core_clk) disable iff (!nrst)
        awvalid |-> s_r.op >= clc_pkg::CLC_OP_WLU)
        else $error("read kind on write address channel");

    a_busy_ready: assert property (@(posedge core_clk) disable iff (!nrst)
        arvalid || awvalid || wvalid || wd_ready |-> !req_ready)
        else $error("new request accepted while busy");

    a_ans_next: assert property (@(posedge core_clk) disable iff (!nrst)
        ce && req_valid && req_ready |=> arvalid || awvalid)
        else $error("taken request not issued next cycle");

    a_line_bounds: assert property (@(posedge core_clk)
        LINE_BYTES >= `CLC_LINE_MIN && LINE_BYTES >= BUS_BYTES &&
        LINE_BYTES <= `CLC_LINE_MAX && LINE_BYTES <= `CLC_BEATS_MAX * BUS_BYTES)
        else $error("line size out of range");

endmodule

// *** rtl/clc_regs.svh ***
// Constants for the cache-line transaction issuer
// Operation
// - Twelve coherent transaction kinds are always exactly one cache line long.
// - Cache-line transactions use bursts of 1, 2, 4, 8 or 16 beats only.
// - Bytes per beat always equals the full data bus width.
// - Incrementing bursts start on a cache line boundary.
// - Wrapping bursts start on a beat boundary only.
// - Most kinds carry the inner or outer shareable domain.
// - Clean, invalidate and write-evict kinds never carry the system domain.
// - Barrier attribute always shows a normal access.
// - Nine kinds always use normal, never exclusive, access.
// - Read-clean, read-shared and clean-unique may use exclusive access.
// - Protection and quality-of-service values pass through unconstrained.
// - Full-line unique writes assert every strobe on every beat.
// - Dataless kinds still encode the full line in burst length.
// - Line size is at least 16 bytes and at least the bus width.
// - Line size is at most 2048 bytes and 16 beats of bus width.
`ifndef CLC_REGS_SVH
`define CLC_REGS_SVH

// Domain codes
`define CLC_DOM_NONSH 2'h0
`define CLC_DOM_INNER 2'h1
`define CLC_DOM_OUTER 2'h2
`define CLC_DOM_SYSTEM 2'h3

// Burst type codes
`define CLC_BURST_FIXED 2'h0
`define CLC_BURST_INCR 2'h1
`define CLC_BURST_WRAP 2'h2

// Fixed attributes
`define CLC_BAR_NORMAL 2'h0
`define CLC_CACHE_VAL 4'hF
`define CLC_CACHE_MOD_BIT 1
`define CLC_LOCK_NORMAL 1'h0

// Write snoop codes
`define CLC_SNP_WLU 4'h1
`define CLC_SNP_EVICT 4'h4
`define CLC_SNP_WEVICT 4'h5

// Read snoop codes
`define CLC_SNP_RCLEAN 4'h1
`define CLC_SNP_RNSD 4'h2
`define CLC_SNP_RSHARED 4'h3
`define CLC_SNP_RUNIQUE 4'h4
`define CLC_SNP_CUNIQUE 4'h5
`define CLC_SNP_MUNIQUE 4'h6
`define CLC_SNP_CSHARED 4'h7
`define CLC_SNP_CINVAL 4'h8
`define CLC_SNP_MINVAL 4'h9

// Line size limits
`define CLC_LINE_MIN 16
`define CLC_LINE_MAX 2048
`define CLC_BEATS_MAX 16

`endif

// *** rtl/clc_pkg.sv ***
// Types for the cache-line transaction issuer
package clc_pkg;

    typedef enum logic [3:0] {
        CLC_OP_RCLEAN = 4'h0,
        CLC_OP_RNSD = 4'h1,
        CLC_OP_RSHARED = 4'h2,
        CLC_OP_RUNIQUE = 4'h3,
        CLC_OP_CUNIQUE = 4'h4,
        CLC_OP_MUNIQUE = 4'h5,
        CLC_OP_CSHARED = 4'h6,
        CLC_OP_CINVAL = 4'h7,
        CLC_OP_MINVAL = 4'h8,
        CLC_OP_WLU = 4'h9,
        CLC_OP_WEVICT = 4'hA,
        CLC_OP_EVICT = 4'hB
    } clc_op_e;

    typedef enum logic [1:0] {
        CLC_ST_IDLE = 2'h0,
        CLC_ST_ADDR = 2'h1,
        CLC_ST_DATA = 2'h3
    } clc_st_e;

    typedef struct packed {
        logic [3:0] snoop;
        logic [1:0] domain;
        logic lock;
        logic is_write;
        logic has_data;
    } clc_attr_s;

    typedef struct packed {
        logic [1:0] burst;
        logic [7:0] len;
        logic [2:0] size;
        logic lock;
        logic [3:0] cache;
        logic [2:0] prot;
        logic [3:0] qos;
        logic [1:0] domain;
        logic [1:0] bar;
        logic [3:0] snoop;
    } clc_chan_s;

endpackage

// *** rtl/clc_attr.sv ***
// Per-kind attribute decode and legalisation
`timescale 1ns/100ps
`include "clc_regs.svh"
module clc_attr (
    // Request
    input wire clc_pkg::clc_op_e op,
    input wire logic [1:0] domain_in,
    input wire logic excl_in,
    // Decoded attributes
    output clc_pkg::clc_attr_s attr
);

    function automatic logic f_relaxed_dom(input clc_pkg::clc_op_e o);
        f_relaxed_dom = (o == clc_pkg::CLC_OP_CSHARED) || (o == clc_pkg::CLC_OP_CINVAL) ||
                        (o == clc_pkg::CLC_OP_MINVAL) || (o == clc_pkg::CLC_OP_WEVICT);
    endfunction

    function automatic logic f_excl_ok(input clc_pkg::clc_op_e o);
        f_excl_ok = (o == clc_pkg::CLC_OP_RCLEAN) || (o == clc_pkg::CLC_OP_RSHARED) ||
                    (o == clc_pkg::CLC_OP_CUNIQUE);
    endfunction

    function automatic logic [3:0] f_snoop(input clc_pkg::clc_op_e o);
        case (o)
            clc_pkg::CLC_OP_RCLEAN: f_snoop = `CLC_SNP_RCLEAN;
            clc_pkg::CLC_OP_RNSD: f_snoop = `CLC_SNP_RNSD;
            clc_pkg::CLC_OP_RSHARED: f_snoop = `CLC_SNP_RSHARED;
            clc_pkg::CLC_OP_RUNIQUE: f_snoop = `CLC_SNP_RUNIQUE;
            clc_pkg::CLC_OP_CUNIQUE: f_snoop = `CLC_SNP_CUNIQUE;
            clc_pkg::CLC_OP_MUNIQUE: f_snoop = `CLC_SNP_MUNIQUE;
            clc_pkg::CLC_OP_CSHARED: f_snoop = `CLC_SNP_CSHARED;
            clc_pkg::CLC_OP_CINVAL: f_snoop = `CLC_SNP_CINVAL;
            clc_pkg::CLC_OP_MINVAL: f_snoop = `CLC_SNP_MINVAL;
            clc_pkg::CLC_OP_WLU: f_snoop = `CLC_SNP_WLU;
            clc_pkg::CLC_OP_WEVICT: f_snoop = `CLC_SNP_WEVICT;
            default: f_snoop = `CLC_SNP_EVICT;
        endcase
    endfunction

    always_comb begin
        attr.snoop = f_snoop(op);
        attr.is_write = (op == clc_pkg::CLC_OP_WLU) || (op == clc_pkg::CLC_OP_WEVICT) ||
                        (op == clc_pkg::CLC_OP_EVICT);
        attr.has_data = (op == clc_pkg::CLC_OP_WLU) || (op == clc_pkg::CLC_OP_WEVICT);
        // Relaxed kinds: system domain becomes outer
        if (f_relaxed_dom(op)) begin
            attr.domain = (domain_in == `CLC_DOM_SYSTEM) ? `CLC_DOM_OUTER : domain_in;
        end else if (domain_in == `CLC_DOM_INNER || domain_in == `CLC_DOM_OUTER) begin
            attr.domain = domain_in;
        end else begin
            attr.domain = `CLC_DOM_INNER;
        end
        // Exclusive only where permitted
        attr.lock = f_excl_ok(op) ? excl_in : `CLC_LOCK_NORMAL;
    end

endmodule

// *** testbench/clc_ic_model.sv ***
// Interconnect stand-in that takes address and write beats, promptly or with stalls
`timescale 1ns/100ps
module clc_ic_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Stall control
    input wire logic slow,
    input wire logic [2:0] stall,
    // Ready outputs
    output logic arready,
    output logic awready,
    output logic wready
);
    // Ready changes only just after an edge; stalls follow the random pattern when slow
    always @(posedge core_clk) begin
        {arready, awready, wready} <= !nrst ? 3'h0 : (slow ? stall : 3'h7);
    end
endmodule

// *** testbench/clc_master_bench.sv ***
// Self-checking bench for the cache-line transaction issuer
`timescale 1ns/100ps
`include "clc_regs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t value mismatch", $time); end end
module clc_master_bench;
    localparam int DW = 64;
    localparam int AW = 32;
    localparam int LB = 64;
    localparam int BEATS = LB / (DW / 8);
    typedef struct packed { logic is_ar; logic [AW-1:0] addr; clc_pkg::clc_chan_s ch; } clc_exp_s;
    typedef struct packed { logic [DW-1:0] d; logic last; } clc_beat_s;
    logic core_clk, nrst, ce, req_valid, req_ready, req_excl, req_wrap, wd_valid, wd_ready;
    logic arvalid, arready, awvalid, awready, wvalid, wready, wlast, slow, ce_rand;
    clc_pkg::clc_op_e req_op;
    logic [AW-1:0] req_addr, araddr, awaddr;
    logic [1:0] req_domain;
    logic [2:0] req_prot, stall;
    logic [3:0] req_qos;
    logic [DW-1:0] wd_data, wdata;
    logic [DW/8-1:0] wstrb;
    clc_pkg::clc_chan_s ar_chan, aw_chan;
    logic [31:0] seed = 32'h0000_be2e;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    clc_exp_s qa[$];
    clc_beat_s qb[$];
    clc_beat_s b;

    clc_master #(.DATA_W(DW), .ADDR_W(AW), .LINE_BYTES(LB)) uut (
        .core_clk(core_clk), .nrst(nrst), .ce(ce), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_domain(req_domain),
        .req_excl(req_excl), .req_wrap(req_wrap), .req_prot(req_prot), .req_qos(req_qos),
        .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .ar_chan(ar_chan), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .aw_chan(aw_chan), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .wlast(wlast)
    );

    clc_ic_model partner (
        .core_clk(core_clk), .nrst(nrst), .slow(slow), .stall(stall),
        .arready(arready), .awready(awready), .wready(wready)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected address-channel beat for one request
    function automatic clc_exp_s expect_of(clc_pkg::clc_op_e op, logic [AW-1:0] a,
            logic [1:0] dom, logic ex, logic wr, logic [2:0] pr, logic [3:0] q);
        clc_exp_s e;
        logic relaxed;
        relaxed = op inside {clc_pkg::CLC_OP_CSHARED, clc_pkg::CLC_OP_CINVAL,
            clc_pkg::CLC_OP_MINVAL, clc_pkg::CLC_OP_WEVICT};
        e.is_ar = (op <= clc_pkg::CLC_OP_MINVAL);
        e.ch.snoop = e.is_ar ? op + 4'h1 : (op == clc_pkg::CLC_OP_WLU ? `CLC_SNP_WLU :
            (op == clc_pkg::CLC_OP_EVICT ? `CLC_SNP_EVICT : `CLC_SNP_WEVICT));
        if (relaxed)
            e.ch.domain = (dom == `CLC_DOM_SYSTEM) ? `CLC_DOM_OUTER : dom;
        else
            e.ch.domain = (dom == `CLC_DOM_NONSH || dom == `CLC_DOM_SYSTEM) ? `CLC_DOM_INNER : dom;
        e.ch.lock = ex && (op inside {clc_pkg::CLC_OP_RCLEAN, clc_pkg::CLC_OP_RSHARED,
            clc_pkg::CLC_OP_CUNIQUE});
        e.ch.burst = (wr && BEATS > 1) ? `CLC_BURST_WRAP : `CLC_BURST_INCR;
        e.addr = (wr && BEATS > 1) ? (a & ~AW'(DW / 8 - 1)) : (a & ~AW'(LB - 1));
        e.ch.len = 8'(BEATS - 1);
        e.ch.size = 3'($clog2(DW / 8));
        e.ch.cache = `CLC_CACHE_VAL;
        e.ch.bar = `CLC_BAR_NORMAL;
        e.ch.prot = pr;
        e.ch.qos = q;
        return e;
    endfunction

    task automatic take_addr(logic is_ar, logic [AW-1:0] a, clc_pkg::clc_chan_s c);
        clc_exp_s e;
        `CHK(qa.size() != 0, 1'b1)
        if (qa.size() != 0) begin
            e = qa.pop_front();
            `CHK(is_ar, e.is_ar)
            `CHK(c.snoop, e.ch.snoop)
            `CHK(c.len, e.ch.len)
            `CHK(c.size, e.ch.size)
            `CHK(a, e.addr)
            `CHK(c.burst, e.ch.burst)
            `CHK(c.domain, e.ch.domain)
            `CHK(c.bar, e.ch.bar)
            `CHK(c.cache, e.ch.cache)
            `CHK(c.lock, e.ch.lock)
            `CHK({c.prot, c.qos}, {e.ch.prot, e.ch.qos})
        end
    endtask

    // Output watcher
    always @(posedge core_clk) begin
        if (nrst && ce && arvalid && arready)
            take_addr(1'b1, araddr, ar_chan);
        if (nrst && ce && awvalid && awready)
            take_addr(1'b0, awaddr, aw_chan);
        if (nrst && ce && wvalid && wready) begin
            `CHK(qb.size() != 0, 1'b1)
            if (qb.size() != 0) begin
                b = qb.pop_front();
                `CHK(wdata, b.d)
                `CHK(wstrb, {(DW / 8){1'b1}})
                `CHK(wlast, b.last)
            end
        end
    end

    // Background stalls and clock-enable gaps
    always @(negedge core_clk) begin
        stall = 3'(xs());
        ce = ce_rand ? (xs() % 8 != 0) : 1'b1;
    end

    task automatic wait_take(logic data_side);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!(ce && (data_side ? wd_ready : req_ready)) && n < 300);
        if (n >= 300) begin
            mismatches++;
            $display("BAD %0t handshake stuck", $time);
        end
        @(negedge core_clk);
    endtask

    task automatic send(clc_pkg::clc_op_e op, logic [1:0] dom, logic ex, logic wr);
        logic [AW-1:0] a;
        logic [2:0] pr;
        logic [3:0] q;
        a = xs();
        pr = 3'(xs());
        q = 4'(xs());
        @(negedge core_clk);
        req_op = op;
        {req_addr, req_domain, req_excl, req_wrap} = {a, dom, ex, wr};
        {req_prot, req_qos} = {pr, q};
        req_valid = 1'b1;
        qa.push_back(expect_of(op, a, dom, ex, wr, pr, q));
        wait_take(1'b0);
        req_valid = 1'b0;
        if (op == clc_pkg::CLC_OP_WLU || op == clc_pkg::CLC_OP_WEVICT) begin
            for (int i = 0; i < BEATS; i++) begin
                wd_data = {xs(), xs()};
                wd_valid = 1'b1;
                qb.push_back('{wd_data, i == BEATS - 1});
                wait_take(1'b1);
            end
            wd_valid = 1'b0;
        end
    endtask

    task automatic finish_test();
        if (qa.size() != 0 || qb.size() != 0) begin
            mismatches++;
            $display("BAD %0t expected traffic missing", $time);
        end
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            $display("BAD %0t run too long", $time);
            finish_test();
        end
    end

    initial begin
        {nrst, req_valid, req_excl, req_wrap, wd_valid, slow, ce_rand} = 7'h00;
        {req_addr, req_domain, req_prot, req_qos, wd_data} = '0;
        req_op = clc_pkg::CLC_OP_RCLEAN;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        `CHK({req_ready, wd_ready, arvalid, awvalid, wvalid}, 5'h00)
        nrst = 1'b1;
        @(negedge core_clk);
        `CHK(req_ready, 1'b1)
        // Every kind with every domain, exclusive wish and burst choice, prompt partner
        for (int i = 0; i < 192; i++)
            send(clc_pkg::clc_op_e'(i % 12), 2'(i / 12), 1'(i / 48), 1'(i / 96));
        // Random traffic with a stalling partner and clock-enable gaps
        slow = 1'b1;
        ce_rand = 1'b1;
        for (int i = 0; i < 150; i++)
            send(clc_pkg::clc_op_e'(xs() % 12), 2'(xs()), 1'(xs()), 1'(xs()));
        repeat (100) @(posedge core_clk);
        finish_test();
    end
endmodule
